/* File: rtl/tmm_consts.svh */
`ifndef TMM_CONSTS_SVH
`define TMM_CONSTS_SVH

// Counter value loaded at start and after each timeout.
`define TMM_CNT_LOAD 16'hFFFF
// Counter value that marks a timeout.
`define TMM_CNT_TIMEOUT 16'h0000
// Counter value after reset.
`define TMM_CNT_RESET 16'h0000
// Prescaler value while it is disabled.
`define TMM_PRE_IDLE 8'hFF
// Wave pin level after reset.
`define TMM_WAVE_RESET 1'b0

// Pin action field codes.
`define TMM_ACT_OFF 2'h0
`define TMM_ACT_TOGGLE 2'h1
`define TMM_ACT_ZERO 2'h2
`define TMM_ACT_ONE 2'h3

// Bit positions inside the interrupt enable field.
`define TMM_IE_TIMEOUT 0
`define TMM_IE_GATE 1
`define TMM_IE_COMPARE 2

`endif

/* File: rtl/tmm_pkg.sv */
package tmm_pkg;

  typedef enum logic [2:0] {
    TMM_MODE_PULSE_WIDTH = 3'h4,
    TMM_MODE_PERIOD = 3'h5,
    TMM_MODE_EVENT = 3'h6
  } tmm_mode_t;

  typedef enum logic [2:0] {
    TMM_ST_IDLE = 3'b000,
    TMM_ST_WAIT = 3'b001,
    TMM_ST_RUN = 3'b010,
    TMM_ST_RUN_HIGH = 3'b011,
    TMM_ST_HOLD = 3'b100,
    TMM_ST_DONE = 3'b101
  } tmm_state_t;

endpackage

/* File: rtl/tmm_prescaler.sv */
`timescale 1ns/1ps
`include "tmm_consts.svh"
module tmm_prescaler #(
  parameter int PRE_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic use_ext,
  input wire logic [2:0] tap_sel,
  input wire logic ext_clk_sync,
  output logic tick,
  output logic [PRE_WIDTH-1:0] taps_q
);

  logic sel_now;
  logic sel_prev_q;

  initial begin
    if (PRE_WIDTH != 8) begin
      $error("tmm_prescaler: PRE_WIDTH must be 8");
    end
  end

  // The prescaler counts down from all ones while the timer runs and
  // is parked at all ones otherwise, so its taps extend the count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taps_q <= `TMM_PRE_IDLE;
    end else if (run) begin
      taps_q <= taps_q - 8'h01;
    end else begin
      taps_q <= `TMM_PRE_IDLE;
    end
  end

  assign sel_now = use_ext ? ext_clk_sync : taps_q[tap_sel];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev_q <= 1'b1;
    end else begin
      sel_prev_q <= sel_now;
    end
  end

  // One pulse per falling edge of the selected counter clock.
  assign tick = run & sel_prev_q & ~sel_now;

endmodule

/* File: rtl/tmm_sync.sv */
`timescale 1ns/1ps
module tmm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_q;

  initial begin
    if (WIDTH < 1) begin
      $error("tmm_sync: WIDTH must be at least 1");
    end
  end

  // Only the second stage reads the first one.
  // Both pins idle high, so the stages start high and no false edge follows.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= '1;
      sync_out <= '1;
    end else begin
      stage1_q <= async_in;
      sync_out <= stage1_q;
    end
  end

endmodule

/* File: rtl/tmm_timer.sv */
`timescale 1ns/1ps
`include "tmm_consts.svh"
module tmm_timer #(
  parameter int CNT_WIDTH = 16,
  parameter int PRE_WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic software_run_bit,
  input wire logic prescaler_enable,
  input wire logic gate_enable_bit,
  input wire logic [2:0] operating_select,
  input wire logic [1:0] pin_action_field,
  input wire logic [2:0] irq_enable_bits,
  input wire logic external_clock_select,
  input wire logic [2:0] prescaler_tap_select,
  input wire logic [CNT_WIDTH-1:0] match_value,
  input wire logic gate_input_n,
  input wire logic count_clock_pin,
  input wire logic gate_event_clear,
  input wire logic timeout_clear,
  input wire logic compare_clear,
  output logic [CNT_WIDTH-1:0] count_value_q,
  output logic [PRE_WIDTH-1:0] prescaler_tap_bits_q,
  output logic running_flag_q,
  output logic gate_event_flag_q,
  output logic gate_level_bit_q,
  output logic compare_interrupt_flag_q,
  output logic match_flag_q,
  output logic timeout_flag_q,
  output logic pin_level_flag_q,
  output logic wave_pin_q,
  output logic wave_pin_oe_q,
  output logic irq_q
);

  logic rst_s1_q;
  logic rst_n_q;
  logic [1:0] pins_sync;
  logic gate_level;
  logic ext_clk_sync;
  logic gate_prev_q;
  logic gate_assert;
  logic gate_negate;
  logic sw_enable;
  logic mode_ok;
  tmm_pkg::tmm_state_t state_q;
  tmm_pkg::tmm_state_t state_d;
  logic counting;
  logic tick;
  logic load_pending_q;
  logic [CNT_WIDTH-1:0] cnt_next;
  logic hit_timeout;
  logic hit_match;
  logic gate_flag_set;
  logic [PRE_WIDTH-1:0] taps;
  logic wave_d;

  initial begin
    if (CNT_WIDTH != 16) begin
      $error("tmm_timer: CNT_WIDTH must be 16");
    end
    if (PRE_WIDTH != 8) begin
      $error("tmm_timer: PRE_WIDTH must be 8");
    end
  end

  // Reset is applied at once and released in step with the clock.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  tmm_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(ref_clk),
    .rst_n(rst_n_q),
    .async_in({count_clock_pin, gate_input_n}),
    .sync_out(pins_sync)
  );

  assign gate_level = pins_sync[0];
  assign ext_clk_sync = pins_sync[1];

  // The gate is active low: assertion is a fall of the pin.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gate_prev_q <= 1'b1;
    end else begin
      gate_prev_q <= gate_level;
    end
  end

  assign gate_assert = gate_prev_q & ~gate_level;
  assign gate_negate = ~gate_prev_q & gate_level;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gate_level_bit_q <= 1'b1;
    end else begin
      gate_level_bit_q <= gate_level;
    end
  end

  assign sw_enable = software_run_bit & prescaler_enable;
  assign mode_ok = (operating_select == tmm_pkg::TMM_MODE_PULSE_WIDTH) ||
                   (operating_select == tmm_pkg::TMM_MODE_PERIOD) ||
                   (operating_select == tmm_pkg::TMM_MODE_EVENT);

  always_comb begin
    state_d = state_q;
    gate_flag_set = 1'b0;
    if (!sw_enable || !mode_ok) begin
      state_d = tmm_pkg::TMM_ST_IDLE;
    end else begin
      unique case (state_q)
        tmm_pkg::TMM_ST_IDLE: begin
          if (operating_select == tmm_pkg::TMM_MODE_EVENT &&
              !gate_enable_bit) begin
            state_d = tmm_pkg::TMM_ST_RUN;
          end else begin
            state_d = tmm_pkg::TMM_ST_WAIT;
          end
        end
        tmm_pkg::TMM_ST_WAIT: begin
          if (!gate_level) begin
            state_d = tmm_pkg::TMM_ST_RUN;
          end
        end
        tmm_pkg::TMM_ST_RUN: begin
          if (operating_select == tmm_pkg::TMM_MODE_PULSE_WIDTH) begin
            if (gate_negate) begin
              state_d = tmm_pkg::TMM_ST_DONE;
              gate_flag_set = 1'b1;
            end
          end else if (operating_select == tmm_pkg::TMM_MODE_PERIOD) begin
            if (gate_negate) begin
              state_d = tmm_pkg::TMM_ST_RUN_HIGH;
            end
          end else if (gate_enable_bit && gate_negate) begin
            state_d = tmm_pkg::TMM_ST_HOLD;
            gate_flag_set = 1'b1;
          end
        end
        tmm_pkg::TMM_ST_RUN_HIGH: begin
          if (gate_assert) begin
            state_d = tmm_pkg::TMM_ST_DONE;
            gate_flag_set = 1'b1;
          end
        end
        tmm_pkg::TMM_ST_HOLD: begin
          if (!gate_level) begin
            state_d = tmm_pkg::TMM_ST_RUN;
          end
        end
        tmm_pkg::TMM_ST_DONE: begin
          state_d = tmm_pkg::TMM_ST_DONE;
        end
        default: begin
          state_d = tmm_pkg::TMM_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= tmm_pkg::TMM_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign counting = (state_q == tmm_pkg::TMM_ST_RUN) ||
                    (state_q == tmm_pkg::TMM_ST_RUN_HIGH);

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      running_flag_q <= 1'b0;
    end else begin
      running_flag_q <= (state_d == tmm_pkg::TMM_ST_RUN) ||
                        (state_d == tmm_pkg::TMM_ST_RUN_HIGH);
    end
  end

  tmm_prescaler #(
    .PRE_WIDTH(PRE_WIDTH)
  ) u_pre (
    .clk(ref_clk),
    .rst_n(rst_n_q),
    .run(counting),
    .use_ext(external_clock_select),
    .tap_sel(prescaler_tap_select),
    .ext_clk_sync(ext_clk_sync),
    .tick(tick),
    .taps_q(taps)
  );

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prescaler_tap_bits_q <= `TMM_PRE_IDLE;
    end else begin
      prescaler_tap_bits_q <= taps;
    end
  end

  // A fresh start loads all ones; resuming from a pause keeps the count.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      load_pending_q <= 1'b0;
    end else if (state_q == tmm_pkg::TMM_ST_IDLE ||
                 state_q == tmm_pkg::TMM_ST_WAIT) begin
      load_pending_q <= 1'b1;
    end else if (tick) begin
      load_pending_q <= 1'b0;
    end
  end

  // Decrementing from zero wraps to all ones, which is the reload.
  assign cnt_next = load_pending_q ? `TMM_CNT_LOAD :
                    count_value_q - 16'h0001;
  assign hit_timeout = tick && cnt_next == `TMM_CNT_TIMEOUT;
  assign hit_match = tick && cnt_next == match_value;

  // No preload value ever reaches the counter in these modes.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      count_value_q <= `TMM_CNT_RESET;
    end else if (tick) begin
      count_value_q <= cnt_next;
    end
  end

  // A set arriving with a clear wins in every flag below except match_flag_q, where a timeout clears it over a match.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      timeout_flag_q <= 1'b0;
    end else if (hit_timeout) begin
      timeout_flag_q <= 1'b1;
    end else if (timeout_clear) begin
      timeout_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      match_flag_q <= 1'b0;
    end else if (hit_timeout) begin
      match_flag_q <= 1'b0;
    end else if (hit_match) begin
      match_flag_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      compare_interrupt_flag_q <= 1'b0;
    end else if (hit_match) begin
      compare_interrupt_flag_q <= 1'b1;
    end else if (compare_clear) begin
      compare_interrupt_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gate_event_flag_q <= 1'b0;
    end else if (gate_flag_set) begin
      gate_event_flag_q <= 1'b1;
    end else if (gate_event_clear) begin
      gate_event_flag_q <= 1'b0;
    end
  end

  always_comb begin
    wave_d = wave_pin_q;
    if (hit_timeout) begin
      unique case (pin_action_field)
        `TMM_ACT_OFF: wave_d = wave_pin_q;
        `TMM_ACT_TOGGLE: wave_d = ~wave_pin_q;
        `TMM_ACT_ZERO: wave_d = 1'b0;
        `TMM_ACT_ONE: wave_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wave_pin_q <= `TMM_WAVE_RESET;
      pin_level_flag_q <= `TMM_WAVE_RESET;
      wave_pin_oe_q <= 1'b0;
    end else begin
      wave_pin_q <= wave_d;
      pin_level_flag_q <= wave_d;
      wave_pin_oe_q <= pin_action_field != `TMM_ACT_OFF;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (irq_enable_bits[`TMM_IE_TIMEOUT] & timeout_flag_q) |
               (irq_enable_bits[`TMM_IE_GATE] & gate_event_flag_q) |
               (irq_enable_bits[`TMM_IE_COMPARE] &
                compare_interrupt_flag_q);
    end
  end

endmodule

/* File: sim/tb_tmm_timer.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module tb_tmm_timer;
  logic ref_clk = 1'b0, rstn = 1'b0, sw = 1'b0, gen = 1'b0;
  logic run = 1'b0, gate = 1'b0, clr = 1'b0;
  logic pe = 1'b1, ext = 1'b1;
  logic [2:0] tsel = 3'h0;
  logic [1:0] act = 2'h0;
  logic [2:0] mode = 3'h0, ie = 3'h0;
  logic [15:0] mv = 16'h1234, cnt;
  logic [7:0] taps;
  logic g_n, tin, on, tg, tgl, tc, com, to, lvl, wave, oe, irq;
  int errors = 0, checks = 0;
  tmm_gate_src i_tmm_gate_src (.ref_clk(ref_clk), .run(run),
    .gate_on(gate), .gate_input_n(g_n), .count_clock_pin(tin));
  tmm_timer i_tmm_timer (.ref_clk(ref_clk), .rstn(rstn),
    .software_run_bit(sw), .prescaler_enable(pe), .gate_enable_bit(gen),
    .operating_select(mode), .pin_action_field(act), .irq_enable_bits(ie),
    .external_clock_select(ext), .prescaler_tap_select(tsel),
    .match_value(mv), .gate_input_n(g_n), .count_clock_pin(tin),
    .gate_event_clear(clr), .timeout_clear(clr), .compare_clear(clr),
    .count_value_q(cnt), .prescaler_tap_bits_q(taps), .running_flag_q(on),
    .gate_event_flag_q(tg), .gate_level_bit_q(tgl),
    .compare_interrupt_flag_q(tc), .match_flag_q(com), .timeout_flag_q(to),
    .pin_level_flag_q(lvl), .wave_pin_q(wave), .wave_pin_oe_q(oe),
    .irq_q(irq));
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse(int n);
    run = 1'b1;
    cyc(8 * n);
    run = 1'b0;
    cyc(4);
  endtask
  task automatic gset(logic v);
    gate = v;
    cyc(6);
  endtask
  // The gate, timeout and compare flags are cleared here while stopped, before the next measurement.
  task automatic start(logic [2:0] m, logic ge);
    sw = 1'b0;
    clr = 1'b1;
    cyc(2);
    clr = 1'b0;
    mode = m;
    gen = ge;
    sw = 1'b1;
    cyc(4);
  endtask
  // The whole sequence needs about 450 cycles; this allows four times that.
  initial begin
    #9000;
    errors++;
    print_verdict();
  end
  initial begin
    cyc(16);
    rstn = 1'b1;
    cyc(8);
    `CHK(oe, 1'b0)
    act = 2'h1;
    cyc(8);
    `CHK(oe, 1'b1)
    start(tmm_pkg::TMM_MODE_PULSE_WIDTH, 1'b1);
    `CHK(taps, 8'hFF)
    gset(1'b1);
    `CHK({on, tgl}, 2'b10)
    pulse(5);
    gset(1'b0);
    `CHK({cnt, tg, on, tgl, irq}, {16'hFFFB, 4'hA})
    `CHK(~cnt + 16'h0001, 16'h0005)
    pulse(3);
    gset(1'b1);
    pulse(2);
    `CHK(cnt, 16'hFFFB)
    gset(1'b0);
    start(tmm_pkg::TMM_MODE_PERIOD, 1'b1);
    gset(1'b1);
    pulse(3);
    gset(1'b0);
    pulse(2);
    `CHK({on, tg}, 2'b10)
    gset(1'b1);
    `CHK({cnt, tg, on}, {16'hFFFB, 2'b10})
    pulse(2);
    gset(1'b0);
    `CHK(cnt, 16'hFFFB)
    mv = 16'hFFFD;
    start(tmm_pkg::TMM_MODE_EVENT, 1'b0);
    pulse(4);
    `CHK({cnt, com, tc}, {16'hFFFC, 2'b11})
    gset(1'b1);
    gset(1'b0);
    pulse(1);
    `CHK({cnt, tg, on}, {16'hFFFB, 2'b01})
    ie = 3'h2;
    start(tmm_pkg::TMM_MODE_EVENT, 1'b1);
    `CHK(tc, 1'b0)
    gset(1'b1);
    pulse(3);
    gset(1'b0);
    `CHK({tg, on, irq}, 3'b101)
    pulse(2);
    `CHK({cnt, tg}, {16'hFFFD, 1'b1})
    gset(1'b1);
    `CHK(on, 1'b1)
    pulse(2);
    `CHK(cnt, 16'hFFFB)
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(2);
    `CHK({tg, irq}, 2'b00)
    // Internal counter clock from prescaler bit 2, enable first held low.
    pe = 1'b0;
    ext = 1'b0;
    tsel = 3'h2;
    start(tmm_pkg::TMM_MODE_EVENT, 1'b0);
    `CHK({on, taps}, {1'b0, 8'hFF})
    pe = 1'b1;
    cyc(22);
    `CHK({cnt, on, taps}, {16'hFFFD, 1'b1, 8'hEB})
    `CHK({com, tc}, 2'b11)
    `CHK({to, wave, lvl}, 3'b000)
    print_verdict();
  end
endmodule

/* File: sim/tmm_gate_src.sv */
`timescale 1ns/1ps
module tmm_gate_src (
  input wire logic ref_clk,
  input wire logic run,
  input wire logic gate_on,
  output logic gate_input_n,
  output logic count_clock_pin
);
  logic [2:0] ph_q = 3'h0;
  // The counting clock stands high between bursts, one fall per 8 cycles.
  always_ff @(posedge ref_clk) begin
    if (run) begin
      ph_q <= ph_q + 3'h1;
    end
  end
  assign count_clock_pin = ~ph_q[2];
  assign gate_input_n = ~gate_on;
endmodule

/* File: sim/tmm_timer_monitor.sv */
`timescale 1ns/1ps
module tmm_timer_monitor #(
  parameter int CNT_WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [1:0] pin_action_field,
  input wire logic [2:0] irq_enable_bits,
  input wire logic [CNT_WIDTH-1:0] match_value,
  input wire logic gate_input_n,
  input wire logic gate_event_clear,
  input wire logic [CNT_WIDTH-1:0] count_value_q,
  input wire logic running_flag_q,
  input wire logic gate_event_flag_q,
  input wire logic gate_level_bit_q,
  input wire logic compare_interrupt_flag_q,
  input wire logic match_flag_q,
  input wire logic timeout_flag_q,
  input wire logic pin_level_flag_q,
  input wire logic wave_pin_q,
  input wire logic wave_pin_oe_q,
  input wire logic irq_q
);
  logic [2:0] flg;
  assign flg = {compare_interrupt_flag_q, gate_event_flag_q, timeout_flag_q};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_level;
    $stable(gate_input_n)[*8] |-> gate_level_bit_q == gate_input_n;
  endproperty
  a_level: assert property (p_level) else $error("gate level");
  property p_tmo;
    $changed(count_value_q) && count_value_q == '0 && match_value != '0
      |-> timeout_flag_q && !match_flag_q;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout flags");
  property p_reload;
    count_value_q == '0 ##1 $changed(count_value_q) |-> count_value_q == '1;
  endproperty
  a_reload: assert property (p_reload) else $error("reload");
  property p_step;
    $changed(count_value_q) && $past(count_value_q) != '0
      |-> count_value_q == $past(count_value_q) - 1'b1 || count_value_q == '1;
  endproperty
  a_step: assert property (p_step) else $error("count step");
  property p_match;
    $changed(count_value_q) && count_value_q == match_value
      && match_value != '0 |-> match_flag_q && compare_interrupt_flag_q;
  endproperty
  a_match: assert property (p_match) else $error("match flags");
  property p_wave;
    pin_level_flag_q == wave_pin_q;
  endproperty
  a_wave: assert property (p_wave) else $error("pin level");
  property p_hold;
    !($changed(count_value_q) && count_value_q == '0) |-> $stable(wave_pin_q);
  endproperty
  a_hold: assert property (p_hold) else $error("pin moved");
  property p_oe;
    $stable(pin_action_field)[*6] |-> wave_pin_oe_q == (pin_action_field != 2'h0);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable");
  property p_irq;
    irq_q == |($past(irq_enable_bits) & $past(flg));
  endproperty
  a_irq: assert property (p_irq) else $error("irq level");
  property p_stop;
    $rose(gate_event_flag_q) |-> ##[0:1] !running_flag_q;
  endproperty
  a_stop: assert property (p_stop) else $error("still running");
  property p_clr;
    $fell(gate_event_flag_q) |-> $past(gate_event_clear);
  endproperty
  a_clr: assert property (p_clr) else $error("gate flag lost");
  c_gate: cover property ($rose(gate_event_flag_q));
  c_match: cover property ($rose(match_flag_q));
  c_run: cover property ($rose(running_flag_q));
endmodule
bind tmm_timer tmm_timer_monitor #(.CNT_WIDTH(CNT_WIDTH)) i_tmm_timer_monitor (
  .ref_clk, .rstn, .pin_action_field, .irq_enable_bits, .match_value,
  .gate_input_n, .gate_event_clear, .count_value_q, .running_flag_q,
  .gate_event_flag_q, .gate_level_bit_q, .compare_interrupt_flag_q,
  .match_flag_q, .timeout_flag_q, .pin_level_flag_q, .wave_pin_q,
  .wave_pin_oe_q, .irq_q);
